// ===== hdl/usr_params.svh
/*
 * Field layout of one queued shift-register command word and the depth
 * of the command queue.
 * Assumes it is included by bare name from files under hdl/.
 */
`ifndef USR_PARAMS_SVH
`define USR_PARAMS_SVH

`define USR_STAGES 4
`define USR_WORD_W 8
`define USR_FIFO_DEPTH 16

// Command word: {mode[1:0], parallel[3:0], serial_left, serial_right}
`define USR_MODE_HI 7
`define USR_MODE_LO 6
`define USR_PAR_HI 5
`define USR_PAR_LO 2
`define USR_SL_BIT 1
`define USR_SR_BIT 0

`endif

// ===== hdl/usr_pkg.sv
/*
 * Types shared by the universal shift register files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package usr_pkg;
    // Encoding is {mode_select_a, mode_select_b}; order is Gray already
    typedef enum logic [1:0] {
        USR_LOAD = 2'h0,
        USR_SHR = 2'h1,
        USR_HOLD = 2'h3,
        USR_SHL = 2'h2
    } usr_mode_t;
endpackage

`default_nettype wire

// ===== hdl/usr_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock, active-low asynchronous reset, DEPTH a power of two.
 */
`default_nettype none

module usr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;

    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + (AW+1)'(1);
        end else if (pop && !push) begin
            next_count = count - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Ready is registered so the upstream sees a clean flop output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr <= AW'(wr_ptr + 1'b1);
            end
            if (pop) begin
                rd_ptr <= AW'(rd_ptr + 1'b1);
            end
            count <= next_count;
            in_ready <= (next_count != (AW+1)'(DEPTH));
        end
    end
endmodule

`default_nettype wire

// ===== hdl/usr_shift_reg.sv
/*
 * Four-stage universal shift register: load, shift right, shift left, hold.
 * Commands (select, parallel and serial data) queue in a 16-word FIFO and
 * one is applied on each rising edge where advance is high and the queue is not empty.
 * Assumes surrounding logic is synchronous to sys_clk.
 */
`include "usr_params.svh"
`default_nettype none

module usr_shift_reg (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic mode_select_a,
    input wire logic mode_select_b,
    input wire logic par_in_0,
    input wire logic par_in_1,
    input wire logic par_in_2,
    input wire logic par_in_3,
    input wire logic serial_in_left,
    input wire logic serial_in_right,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic advance,
    output logic stage_out_0,
    output logic stage_out_1,
    output logic stage_out_2,
    output logic stage_out_3,
    output var logic op_done
);
    import usr_pkg::*;

    logic [`USR_WORD_W-1:0] in_word;
    logic [`USR_WORD_W-1:0] q_word;
    logic q_valid;
    logic [`USR_STAGES-1:0] stage;
    logic [`USR_STAGES-1:0] next_stage;

    assign in_word = {mode_select_a, mode_select_b,
                      par_in_3, par_in_2, par_in_1, par_in_0,
                      serial_in_left, serial_in_right};

    // The drain side stalls on advance, so the queue can really fill
    usr_fifo #(
        .WIDTH(`USR_WORD_W),
        .DEPTH(`USR_FIFO_DEPTH)
    ) u_cmd_fifo (
        .clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(in_word),
        .out_valid(q_valid),
        .out_ready(advance),
        .out_data(q_word)
    );

    wire pop = q_valid & advance;
    wire usr_mode_t mode = usr_mode_t'(q_word[`USR_MODE_HI:`USR_MODE_LO]);
    wire [`USR_STAGES-1:0] q_par = q_word[`USR_PAR_HI:`USR_PAR_LO];
    wire q_sl = q_word[`USR_SL_BIT];
    wire q_sr = q_word[`USR_SR_BIT];
    wire sel_load = (mode == USR_LOAD);
    wire sel_shr = (mode == USR_SHR);
    wire sel_shl = (mode == USR_SHL);
    wire sel_hold = (mode == USR_HOLD);

    // ext[i] is the neighbour below stage i, ext[i+2] the one above
    wire [`USR_STAGES+1:0] ext = {q_sr, stage, q_sl};

    genvar i;
    generate
        for (i = 0; i < `USR_STAGES; i++) begin : g_stage
            assign next_stage[i] =
                sel_load ? q_par[i] :
                sel_shr ? ext[i+2] :
                sel_shl ? ext[i] :
                stage[i];
        end
    endgenerate

    // No reset on the data stages; a load or four shifts in one direction makes them known
    always_ff @(posedge sys_clk) begin
        if (pop) begin
            stage <= next_stage;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_done <= 1'b0;
        end else begin
            op_done <= pop;
        end
    end

    assign stage_out_0 = stage[0];
    assign stage_out_1 = stage[1];
    assign stage_out_2 = stage[2];
    assign stage_out_3 = stage[3];

    // Shadow fill level, kept only so the assertions can judge in_ready
    logic [4:0] fill_level;
    wire push = in_valid & in_ready;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fill_level <= '0;
        end else begin
            fill_level <= fill_level + 5'(push) - 5'(pop);
        end
    end

    sequence s_load;
        pop && sel_load;
    endsequence

    sequence s_shr;
        pop && sel_shr;
    endsequence

    sequence s_shl;
        pop && sel_shl;
    endsequence

    sequence s_hold;
        pop && sel_hold;
    endsequence

    property p_load;
        @(posedge sys_clk) disable iff (!rst_n)
        s_load |=> stage == $past(q_par);
    endproperty
    a_load: assert property (p_load)
        else $error("parallel load did not take parallel data");

    property p_shr;
        @(posedge sys_clk) disable iff (!rst_n)
        s_shr |=> stage == {$past(q_sr), $past(stage[3:1])};
    endproperty
    a_shr: assert property (p_shr)
        else $error("shift right result wrong");

    property p_shl;
        @(posedge sys_clk) disable iff (!rst_n)
        s_shl |=> stage == {$past(stage[2:0]), $past(q_sl)};
    endproperty
    a_shl: assert property (p_shl)
        else $error("shift left result wrong");

    property p_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        s_hold |=> stage === $past(stage);
    endproperty
    a_hold: assert property (p_hold)
        else $error("hold mode changed a stage");

    // Case equality: stages not yet written stay unknown, which is legal
    property p_idle;
        @(posedge sys_clk) disable iff (!rst_n)
        !pop |=> stage === $past(stage) && !op_done;
    endproperty
    a_idle: assert property (p_idle)
        else $error("stage changed without an applied command");

    property p_done;
        @(posedge sys_clk) disable iff (!rst_n)
        pop |=> op_done ##1 (op_done == $past(pop));
    endproperty
    a_done: assert property (p_done)
        else $error("op_done does not track applied commands");

    property p_pins;
        @(posedge sys_clk) disable iff (!rst_n)
        s_load |=> {stage_out_3, stage_out_2, stage_out_1, stage_out_0}
            == $past(q_word[`USR_PAR_HI:`USR_PAR_LO]);
    endproperty
    a_pins: assert property (p_pins)
        else $error("parallel inputs not mapped to matching outputs");

    property p_fill;
        @(posedge sys_clk) disable iff (!rst_n)
        s_shl [*4] |=> stage == {$past(q_sl, 4), $past(q_sl, 3),
                                 $past(q_sl, 2), $past(q_sl, 1)};
    endproperty
    a_fill: assert property (p_fill)
        else $error("four left shifts did not fill all stages");

    property p_rfill;
        @(posedge sys_clk) disable iff (!rst_n)
        s_shr [*4] |=> stage == {$past(q_sr, 1), $past(q_sr, 2),
                                 $past(q_sr, 3), $past(q_sr, 4)};
    endproperty
    a_rfill: assert property (p_rfill)
        else $error("four right shifts did not fill all stages");

    property p_keep;
        @(posedge sys_clk) disable iff (!rst_n)
        s_load ##1 s_hold |=> stage == $past(q_par, 2);
    endproperty
    a_keep: assert property (p_keep)
        else $error("hold after a load lost the loaded value");

    property p_refuse;
        @(posedge sys_clk) disable iff (!rst_n)
        advance && !q_valid |=> !op_done && stage === $past(stage);
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("advance on an empty queue changed the stages");

    property p_room;
        @(posedge sys_clk) disable iff (!rst_n)
        in_ready == (fill_level != 5'(`USR_FIFO_DEPTH));
    endproperty
    a_room: assert property (p_room)
        else $error("in_ready disagrees with the queue fill level");
endmodule

`default_nettype wire

// ===== tb/usr_src_model.sv
/* Source model: offers command words on select, data and valid pins.
   Assumes its pins change at the falling edge of sys_clk. */
`default_nettype none
module usr_src_model (
    input wire logic sys_clk,
    input wire logic in_ready,
    output logic in_valid,
    output logic [7:0] cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        in_valid = 1'b0;
        cmd = 8'h00;
    end
    // A refused offer stays up until the queue has room
    task automatic send(input logic [7:0] w);
        @(negedge sys_clk);
        in_valid = 1'b1;
        cmd = w;
        while (in_ready !== 1'b1) @(negedge sys_clk);
        @(posedge sys_clk);
    endtask
    // Released lines show the inverse so stale data cannot match
    task automatic idle();
        @(negedge sys_clk);
        in_valid = 1'b0;
        cmd = ~cmd;
    endtask
endmodule
`default_nettype wire

// ===== tb/test_usr_shift_reg.sv
/* Bench for the universal shift register: fills and drains the queue
   through every mode, then checks reset. Assumes the source model. */
`default_nettype none
module test_usr_shift_reg;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic advance = 1'b0;
    logic in_valid, in_ready, op_done;
    logic [7:0] cmd;
    logic [3:0] exp;
    wire [3:0] q;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;

    initial forever #4 sys_clk = ~sys_clk;

    usr_src_model u_src (.sys_clk(sys_clk), .in_ready(in_ready),
        .in_valid(in_valid), .cmd(cmd));

    usr_shift_reg u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .mode_select_a(cmd[7]), .mode_select_b(cmd[6]),
        .par_in_3(cmd[5]), .par_in_2(cmd[4]), .par_in_1(cmd[3]),
        .par_in_0(cmd[2]), .serial_in_left(cmd[1]),
        .serial_in_right(cmd[0]), .in_valid(in_valid),
        .in_ready(in_ready), .advance(advance),
        .stage_out_0(q[0]), .stage_out_1(q[1]), .stage_out_2(q[2]),
        .stage_out_3(q[3]), .op_done(op_done));

    // Word 0 is a load, so later expectations start from known stages
    function automatic logic [7:0] word(input int i);
        return {i[1:0], i[3:0] ^ 4'h5, i[2], ~i[0]};
    endfunction

    function automatic logic [3:0] nx(input logic [3:0] s,
                                      input logic [7:0] w);
        case (w[7:6])
            2'h0: return w[5:2];
            2'h1: return {w[0], s[3:1]};
            2'h2: return {s[2:0], w[1]};
            default: return s;
        endcase
    endfunction

    task automatic chk(input string name, input logic [3:0] e,
                       input logic [3:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic t_after_reset();
        chk("in_ready", 4'h1, {3'h0, in_ready});
        chk("op_done", 4'h0, {3'h0, op_done});
        chk("stages", 4'hX, q);
    endtask

    // Seventeen words: the last is refused until a pop makes room
    task automatic t_fill_drain();
        int k;
        fork
            begin
                for (int i = 0; i < 17; i++) u_src.send(word(i));
                u_src.idle();
            end
        join_none
        repeat (20) @(negedge sys_clk);
        chk("in_ready full", 4'h0, {3'h0, in_ready});
        chk("op_done stalled", 4'h0, {3'h0, op_done});
        advance = 1'b1;
        for (int i = 0; i < 17; i++) begin
            k = 0;
            @(negedge sys_clk);
            while (op_done !== 1'b1 && k < 3) begin
                @(negedge sys_clk);
                k++;
            end
            exp = nx(exp, word(i));
            chk("op_done", 4'h1, {3'h0, op_done});
            chk("stages", exp, q);
        end
        @(negedge sys_clk);
        chk("op_done empty", 4'h0, {3'h0, op_done});
        chk("stages empty", exp, q);
        advance = 1'b0;
    endtask

    // Four shifts each way flush every stage; then a load that a hold keeps
    task automatic t_shift_fill();
        logic [79:0] fill;
        fill = 80'h8281_8282_7E7D_7D7E_24DB;
        for (int i = 0; i < 10; i++) u_src.send(fill[79-8*i -: 8]);
        u_src.idle();
        advance = 1'b1;
        for (int i = 0; i < 10; i++) begin
            @(negedge sys_clk);
            exp = nx(exp, fill[79-8*i -: 8]);
            chk("op_done shift", 4'h1, {3'h0, op_done});
            chk("stages shift", exp, q);
            if (i == 3) chk("left fill", 4'hB, q);
            if (i == 7) chk("right fill", 4'h6, q);
        end
        chk("load then hold", 4'h9, q);
        advance = 1'b0;
    endtask

    task automatic t_reset_keeps();
        rst_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk("stages in reset", exp, q);
        chk("in_ready in reset", 4'h1, {3'h0, in_ready});
        rst_n = 1'b1;
        @(negedge sys_clk);
        chk("stages after reset", exp, q);
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 1000) begin
            miscompares++;
            end_of_test();
        end
    end

    initial begin
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        t_after_reset();
        t_fill_drain();
        t_shift_fill();
        t_reset_keeps();
        end_of_test();
    end
endmodule
`default_nettype wire
